// [rtl/sync2.sv]
// two flip-flop synchroniser for inputs from outside the clock domain
module sync2 #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rstn,
	// data
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	logic [W-1:0] meta_r;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_r <= RST;
			o_q    <= RST;
		end else begin
			meta_r <= i_d;
			o_q    <= meta_r;
		end
	end

endmodule : sync2

// [rtl/sysctl_pkg.sv]
// constants, types and register map for the reset and suspend controller
package sysctl_pkg;

	// clock
	localparam int CLK_HZ        = 40_000_000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int MS_CYCLES     = CLK_HZ / 1000;

	// core reset pulse length after an internal restart
	localparam int RESTART_TIME_NS = 1000;
	localparam int RESTART_CYCLES  = (RESTART_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// watchdog length in low-frequency timer ticks
	localparam logic [15:0] WDT_TICKS = 16'h0100;

	// byte addresses of the register map
	localparam logic [15:0] ADDR_INFO_FLAGS = 16'h1010;
	localparam logic [15:0] ADDR_VER_LO     = 16'h1014;
	localparam logic [15:0] ADDR_VER_HI     = 16'h1015;
	localparam logic [15:0] ADDR_SYS_CTRL   = 16'h11BC;
	localparam logic [15:0] ADDR_GEN_SET    = 16'h11C0;
	localparam logic [15:0] ADDR_CFG        = 16'h11C1;
	localparam logic [15:0] ADDR_TIMEOUT    = 16'h11C2;

	// system control bits
	localparam int SC_ACK_RESET_BIT     = 7;
	localparam int SC_SUSPEND_BIT       = 3;
	localparam int SC_SOFT_RESTART_BIT  = 1;

	// info flag bits
	localparam int INFO_SHOW_RESET_BIT  = 7;
	localparam int INFO_SUSPENDED_BIT   = 1;
	localparam int INFO_SWITCH_BIT      = 0;

	// general settings fields
	localparam int GS_OSC_LSB           = 0;
	localparam int GS_SW_EN_BIT         = 4;
	localparam int GS_SW_POL_BIT        = 5;

	// config bits
	localparam int CFG_EVENT_MODE_BIT   = 0;

	// values after reset
	localparam logic [7:0]  GEN_SET_RST = 8'h00;
	localparam logic [7:0]  CFG_RST     = 8'h00;
	localparam logic [7:0]  TIMEOUT_RST = 8'h14;
	localparam logic [15:0] VER_RST     = 16'h0000;
	localparam logic [7:0]  SYS_CTRL_RST = 8'h00;

	typedef enum logic [1:0] {
		OSC_14MHZ,
		OSC_20MHZ,
		OSC_24MHZ,
		OSC_RESERVED
	} osc_sel_e;

	typedef struct packed {
		logic     sw_pol;
		logic     sw_en;
		osc_sel_e osc;
	} gen_settings_s;

	typedef struct packed {
		logic soft_restart;
		logic suspend;
	} sys_ctrl_s;

endpackage : sysctl_pkg

// [rtl/system_reset_suspend_control.sv]
// reset indication, restart, suspend, watchdog and switch logic with register port
//
// How it works
// - oscillator select field picks 14, 20 or 24 MHz; reserved code ignored
// - every reset sets the show-reset flag in info flags
// - flag stays until host writes ack-reset; a new reset wins over ack
// - while show-reset is set, event mode is ignored; window every cycle
// - soft restart bit restarts the device once the current window ends
// - window end with suspend bit set stops processing, low power, data kept
// - wake by forced comms; host clears suspend bit in that session
// - leaving suspend pulses a reseed of trackpad references
// - watchdog on low-frequency timer, kicked each loop; expiry forces cold restart
// - switch pin is read only while switch enable is set
// - polarity setting chooses whether high or low means pressed
// - switch-pressed flag follows the corrected switch state
// - registers use 16-bit byte addresses, one byte per address
// - two-byte values sit least significant byte first, word aligned
// - bus runs up to fast-mode-plus; byte engine outside this block
// - two-byte settings version is writable and reads back
// - ready line driven low while a window is open
// - unserviced window ends after a non-zero timeout in ms, ready released
//
// Local design decisions: the address map and the plain strobed port.
module system_reset_suspend_control
	import sysctl_pkg::*;
#(
	parameter int MS_CNT = MS_CYCLES
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// register port
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	// processing core
	input  wire logic        i_cycle_done,
	input  wire logic        i_event,
	input  wire logic        i_loop_kick,
	input  wire logic        i_comm_end,
	input  wire logic        i_force_comms,
	output logic             o_processing_en,
	output logic             o_low_power,
	output logic             o_reseed,
	output logic             o_core_reset,
	output logic      [1:0]  o_osc_sel,
	output logic             o_switch_pressed,
	// pins
	input  wire logic        i_hardware_reset_pin_n,
	input  wire logic        i_low_freq_timer,
	input  wire logic        i_switch,
	output logic             o_rdy_o,
	output logic             o_rdy_oe
);

	typedef enum logic [1:0] {
		ST_PROCESS,
		ST_WINDOW,
		ST_SUSPEND,
		ST_RESTART
	} state_e;
	// settings defaults taken field by field; unused byte bits have no home in the struct
	localparam gen_settings_s GEN_DEF = gen_settings_s'({GEN_SET_RST[GS_SW_POL_BIT],
		GEN_SET_RST[GS_SW_EN_BIT], GEN_SET_RST[GS_OSC_LSB+:2]});

	state_e        state_r;
	state_e        state_nxt;
	gen_settings_s gen_r;
	logic          event_mode_r;
	logic [7:0]    timeout_r;
	logic [15:0]   version_r;
	sys_ctrl_s     ctrl_r;
	logic          show_reset_r;
	logic          switch_pressed_r;
	logic          woke_r;
	logic [7:0]    restart_cnt_r;
	logic [31:0]   ms_pre_r;
	logic [7:0]    ms_cnt_r;
	logic [15:0]   wdt_cnt_r;
	logic          lf_prev_r;
	logic [7:0]    rdata_r;

	logic          pin_rst_n_s;
	logic          lf_s;
	logic          switch_s;
	logic          sys_clear;
	logic          win_end;
	logic          tmo;
	logic          wdt_expire;
	logic          lf_tick;
	logic          want_window;
	logic          ack_wr;
	logic          restart_req;

	// pins pass two flops before use; reset pin idles high so no false restart
	sync2 #(
		.W   (3),
		.RST (3'b100)
	) u_sync_pins (
		.i_clk  (i_clk),
		.i_rstn (i_rstn),
		.i_d    ({i_hardware_reset_pin_n, i_low_freq_timer, i_switch}),
		.o_q    ({pin_rst_n_s, lf_s, switch_s})
	);

	function automatic logic reg_hit(input logic [15:0] a, input logic [15:0] b);
		reg_hit = (a == b);
	endfunction : reg_hit
	function automatic logic pressed(input logic lvl, input logic pol);
		pressed = pol ? lvl : ~lvl;
	endfunction : pressed

	assign sys_clear = (state_r == ST_RESTART);
	assign ack_wr    = i_wr && reg_hit(i_addr, ADDR_SYS_CTRL) && i_wdata[SC_ACK_RESET_BIT];

	// window control
	assign tmo     = (state_r == ST_WINDOW) && (timeout_r != 8'h00) && (ms_cnt_r >= timeout_r);
	assign win_end = (state_r == ST_WINDOW) && (i_comm_end || tmo);

	// event mode bypassed until the reset has been acknowledged
	assign want_window = !event_mode_r || show_reset_r || i_event;

	// watchdog
	assign lf_tick    = lf_s && !lf_prev_r;
	assign wdt_expire = (wdt_cnt_r >= WDT_TICKS);

	// pin reset is honoured at any time; keeping it outside windows is the host's job
	assign restart_req = !pin_rst_n_s || wdt_expire;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_PROCESS: begin
				if (i_cycle_done && want_window) begin
					state_nxt = ST_WINDOW;
				end
			end
			ST_WINDOW: begin
				if (win_end) begin
					if (ctrl_r.soft_restart) begin
						state_nxt = ST_RESTART;
					end else if (ctrl_r.suspend) begin
						state_nxt = ST_SUSPEND;
					end else begin
						state_nxt = ST_PROCESS;
					end
				end
			end
			ST_SUSPEND: begin
				if (i_force_comms) begin
					state_nxt = ST_WINDOW;
				end
			end
			ST_RESTART: begin
				if (restart_cnt_r >= 8'(RESTART_CYCLES - 1) && pin_rst_n_s) begin
					state_nxt = ST_PROCESS;
				end
			end
			default: begin
				state_nxt = ST_PROCESS;
			end
		endcase
		if (restart_req) begin
			state_nxt = ST_RESTART;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= ST_PROCESS;
		end else begin
			state_r <= state_nxt;
		end
	end

	// restart pulse length
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			restart_cnt_r <= 8'h00;
		end else if (state_r == ST_RESTART && state_nxt == ST_RESTART) begin
			if (restart_cnt_r != 8'hFF) begin
				restart_cnt_r <= restart_cnt_r + 8'h01;
			end
		end else begin
			restart_cnt_r <= 8'h00;
		end
	end

	// millisecond timer, runs only while a window is open
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ms_pre_r <= 32'h0;
			ms_cnt_r <= 8'h00;
		end else if (state_r != ST_WINDOW) begin
			ms_pre_r <= 32'h0;
			ms_cnt_r <= 8'h00;
		end else if (ms_pre_r >= 32'(MS_CNT - 1)) begin
			ms_pre_r <= 32'h0;
			if (ms_cnt_r != 8'hFF) begin
				ms_cnt_r <= ms_cnt_r + 8'h01;
			end
		end else begin
			ms_pre_r <= ms_pre_r + 32'h1;
		end
	end

	// watchdog, counted on low-frequency ticks; held at zero while in suspend
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wdt_cnt_r <= 16'h0000;
			lf_prev_r <= 1'b0;
		end else begin
			lf_prev_r <= lf_s;
			if (sys_clear || i_loop_kick || state_r == ST_SUSPEND) begin
				wdt_cnt_r <= 16'h0000;
			end else if (lf_tick) begin
				wdt_cnt_r <= wdt_cnt_r + 16'h0001;
			end
		end
	end

	// show-reset: set by every reset, cleared by ack; the set wins
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			show_reset_r <= 1'b1;
		end else if (sys_clear) begin
			show_reset_r <= 1'b1;
		end else if (ack_wr) begin
			show_reset_r <= 1'b0;
		end
	end

	// settings registers return to defaults on every restart
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			gen_r <= GEN_DEF;
		end else if (sys_clear) begin
			gen_r <= GEN_DEF;
		end else if (i_wr && reg_hit(i_addr, ADDR_GEN_SET)) begin
			gen_r.sw_pol <= i_wdata[GS_SW_POL_BIT];
			gen_r.sw_en  <= i_wdata[GS_SW_EN_BIT];
			// reserved code would leave the oscillator undefined, so keep the old one
			if (i_wdata[GS_OSC_LSB+:2] != 2'b11) begin
				gen_r.osc <= osc_sel_e'(i_wdata[GS_OSC_LSB+:2]);
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			event_mode_r <= CFG_RST[CFG_EVENT_MODE_BIT];
			timeout_r    <= TIMEOUT_RST;
		end else if (sys_clear) begin
			event_mode_r <= CFG_RST[CFG_EVENT_MODE_BIT];
			timeout_r    <= TIMEOUT_RST;
		end else if (i_wr && reg_hit(i_addr, ADDR_CFG)) begin
			event_mode_r <= i_wdata[CFG_EVENT_MODE_BIT];
		end else if (i_wr && reg_hit(i_addr, ADDR_TIMEOUT)) begin
			timeout_r <= i_wdata;
		end
	end

	// settings version, low byte at the even address
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			version_r <= VER_RST;
		end else if (sys_clear) begin
			version_r <= VER_RST;
		end else if (i_wr && reg_hit(i_addr, ADDR_VER_LO)) begin
			version_r[7:0] <= i_wdata;
		end else if (i_wr && reg_hit(i_addr, ADDR_VER_HI)) begin
			version_r[15:8] <= i_wdata;
		end
	end

	// system control; soft restart is consumed by the restart itself
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl_r <= sys_ctrl_s'(2'b00);
		end else if (sys_clear) begin
			ctrl_r <= sys_ctrl_s'(2'b00);
		end else if (i_wr && reg_hit(i_addr, ADDR_SYS_CTRL)) begin
			ctrl_r.suspend      <= i_wdata[SC_SUSPEND_BIT];
			ctrl_r.soft_restart <= i_wdata[SC_SOFT_RESTART_BIT];
		end
	end

	// remember that the current window was forced out of suspend
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			woke_r <= 1'b0;
		end else if (state_r == ST_SUSPEND && i_force_comms) begin
			woke_r <= 1'b1;
		end else if (state_r != ST_WINDOW || win_end) begin
			woke_r <= 1'b0;
		end
	end

	// reseed pulse when leaving suspend
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_reseed <= 1'b0;
		end else begin
			o_reseed <= woke_r && win_end && (state_nxt == ST_PROCESS);
		end
	end

	// switch input, sampled only when enabled
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			switch_pressed_r <= 1'b0;
		end else if (!gen_r.sw_en) begin
			switch_pressed_r <= 1'b0;
		end else begin
			switch_pressed_r <= pressed(switch_s, gen_r.sw_pol);
		end
	end

	// read data one cycle after the strobe; unmapped bytes read zero
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_r <= 8'h00;
		end else if (i_rd) begin
			case (i_addr)
				ADDR_INFO_FLAGS: begin
					rdata_r <= 8'h00;
					rdata_r[INFO_SHOW_RESET_BIT] <= show_reset_r;
					rdata_r[INFO_SUSPENDED_BIT]  <= (state_r == ST_SUSPEND);
					rdata_r[INFO_SWITCH_BIT]     <= switch_pressed_r;
				end
				ADDR_VER_LO: rdata_r <= version_r[7:0];
				ADDR_VER_HI: rdata_r <= version_r[15:8];
				ADDR_SYS_CTRL: begin
					rdata_r <= 8'h00;
					rdata_r[SC_SUSPEND_BIT]      <= ctrl_r.suspend;
					rdata_r[SC_SOFT_RESTART_BIT] <= ctrl_r.soft_restart;
				end
				ADDR_GEN_SET: begin
					rdata_r <= 8'h00;
					rdata_r[GS_OSC_LSB+:2] <= gen_r.osc;
					rdata_r[GS_SW_EN_BIT]  <= gen_r.sw_en;
					rdata_r[GS_SW_POL_BIT] <= gen_r.sw_pol;
				end
				ADDR_CFG: rdata_r <= 8'(event_mode_r) << CFG_EVENT_MODE_BIT;
				ADDR_TIMEOUT: rdata_r <= timeout_r;
				default: rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	// outputs
	assign o_rdata          = rdata_r;
	assign o_switch_pressed = switch_pressed_r;
	assign o_osc_sel        = gen_r.osc;
	assign o_core_reset     = sys_clear;
	// suspended core keeps its memory, only processing stops
	assign o_processing_en  = (state_r == ST_PROCESS);
	assign o_low_power      = (state_r == ST_SUSPEND);
	// open drain: only ever pulls low
	assign o_rdy_o          = 1'b0;
	assign o_rdy_oe         = (state_r == ST_WINDOW);

endmodule : system_reset_suspend_control

// [testbench/host_model.sv]
// host side: watches the ready line and ends a session after a delay while serve is set
module host_model (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	// ready line parts
	input  wire logic       i_rdy_o,
	input  wire logic       i_rdy_oe,
	// control from bench
	input  wire logic       i_serve,
	input  wire logic [3:0] i_delay,
	// session end
	output logic            o_comm_end
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       rdy_n;
	logic [3:0] cnt_r;

	// released line floats to the pull-up level
	assign rdy_n = i_rdy_oe ? i_rdy_o : 1'b1;

	// only talks inside a window; ends it with one pulse
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_r      <= 4'h0;
			o_comm_end <= 1'b0;
		end else begin
			o_comm_end <= 1'b0;
			if (rdy_n || o_comm_end) begin
				cnt_r <= 4'h0;
			end else if (i_serve) begin
				o_comm_end <= (cnt_r == i_delay);
				cnt_r      <= cnt_r + 4'h1;
			end
		end
	end
endmodule : host_model

// [testbench/sysctl_checker.sv]
// port assertions for the reset and suspend controller
module sysctl_checker (
	// clock and reset
	input wire logic       i_clk,
	input wire logic       i_rstn,
	// stimulus
	input wire logic       i_rd,
	input wire logic       i_cycle_done,
	input wire logic       i_comm_end,
	input wire logic       i_force_comms,
	// responses
	input wire logic [7:0] o_rdata,
	input wire logic       o_processing_en,
	input wire logic       o_low_power,
	input wire logic       o_reseed,
	input wire logic       o_core_reset,
	input wire logic       o_rdy_o,
	input wire logic       o_rdy_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside answer cycle");
	chk_ready_low: assert property (o_rdy_o == 1'b0)
		else $error("ready line driven high");
	chk_window_cause: assert property ($rose(o_rdy_oe) |->
		$past(i_cycle_done || (o_low_power && i_force_comms)))
		else $error("window opened without cause");
	chk_window_close: assert property (o_rdy_oe && i_comm_end |=> !o_rdy_oe)
		else $error("window stayed open after session end");
	chk_suspend_quiet: assert property (o_low_power |-> !o_processing_en && !o_rdy_oe)
		else $error("activity while suspended");
	chk_suspend_entry: assert property ($rose(o_low_power) |-> $past(o_rdy_oe))
		else $error("suspend entered outside a session end");
	chk_force_wake: assert property (o_low_power && i_force_comms |=> o_rdy_oe)
		else $error("forced comms did not open a window");
	chk_reseed_pulse: assert property (o_reseed |-> o_processing_en ##1 !o_reseed)
		else $error("reseed not a single pulse while processing");
	chk_restart_len: assert property ($rose(o_core_reset) |->
		(!o_processing_en && !o_rdy_oe)[*8] ##32 o_core_reset)
		else $error("restart pulse too short");

	cover property ($rose(o_low_power));
	cover property (o_reseed);
	cover property ($rose(o_core_reset));
endmodule : sysctl_checker

// [testbench/system_reset_suspend_control_test.sv]
// self-checking bench for the reset and suspend controller
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module system_reset_suspend_control_test import sysctl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk, i_rstn, i_wr, i_rd, i_cycle_done, i_event, i_loop_kick;
	logic        i_force_comms, i_comm_end, i_hardware_reset_pin_n, i_low_freq_timer;
	logic        i_switch, serve, o_processing_en, o_low_power, o_reseed, o_core_reset;
	logic        o_switch_pressed, o_rdy_o, o_rdy_oe;
	logic [15:0] i_addr;
	logic [7:0]  i_wdata, o_rdata, d;
	logic [1:0]  o_osc_sel;
	int          failures, tests_run;

	system_reset_suspend_control #(.MS_CNT(10)) uut (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_cycle_done(i_cycle_done), .i_event(i_event), .i_loop_kick(i_loop_kick),
		.i_comm_end(i_comm_end), .i_force_comms(i_force_comms),
		.o_processing_en(o_processing_en), .o_low_power(o_low_power), .o_reseed(o_reseed),
		.o_core_reset(o_core_reset), .o_osc_sel(o_osc_sel),
		.o_switch_pressed(o_switch_pressed),
		.i_hardware_reset_pin_n(i_hardware_reset_pin_n),
		.i_low_freq_timer(i_low_freq_timer), .i_switch(i_switch),
		.o_rdy_o(o_rdy_o), .o_rdy_oe(o_rdy_oe));
	host_model host (.i_clk(i_clk), .i_rstn(i_rstn), .i_rdy_o(o_rdy_o),
		.i_rdy_oe(o_rdy_oe), .i_serve(serve), .i_delay(4'h3), .o_comm_end(i_comm_end));

	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	task waitc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : waitc
	task wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge i_clk) begin i_wr <= 1'b1; i_addr <= a; i_wdata <= v; end
		@(posedge i_clk) i_wr <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge i_clk) begin i_rd <= 1'b1; i_addr <= a; end
		@(posedge i_clk) i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask : rd
	task rchk(input logic [15:0] a, input logic [7:0] e);
		rd(a, d);
		`CHK(d, e)
	endtask : rchk
	// pulse bits: cycle done, event, forced comms, loop kick
	task tick(input logic [3:0] p);
		@(posedge i_clk) {i_cycle_done, i_event, i_force_comms, i_loop_kick} <= p;
		@(posedge i_clk) {i_cycle_done, i_event, i_force_comms, i_loop_kick} <= 4'h0;
		#1;
	endtask : tick
	task wait_rdy(input logic v);
		for (int k = 0; k < 200 && o_rdy_oe !== v; k++) waitc(1);
		`CHK(o_rdy_oe, v)
	endtask : wait_rdy
	task close_win;
		@(posedge i_clk) serve <= 1'b1;
		wait_rdy(1'b0);
		@(posedge i_clk) serve <= 1'b0;
		#1;
	endtask : close_win
	task lf(input int n);
		repeat (n) begin
			@(posedge i_clk) i_low_freq_timer <= 1'b1;
			repeat (2) @(posedge i_clk);
			i_low_freq_timer <= 1'b0;
			@(posedge i_clk);
		end
		#1;
	endtask : lf
	task summarize;
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	// generous bound: the sequence needs a few thousand cycles
	initial begin
		#(25 * 20000);
		failures++;
		summarize();
	end

	initial begin
		{i_rstn, i_wr, i_rd, i_cycle_done, i_event, i_loop_kick, i_force_comms, serve} = '0;
		{i_hardware_reset_pin_n, i_low_freq_timer, i_switch} = 3'b100;
		{i_addr, i_wdata} = '0;
		repeat (16) @(posedge i_clk);
		i_rstn <= 1'b1;
		rchk(ADDR_INFO_FLAGS, 8'h80);
		rchk(16'h2000, 8'h00);
		wr(ADDR_CFG, 8'h01);
		tick(4'h8);
		wait_rdy(1'b1);
		close_win();
		rd(ADDR_SYS_CTRL, d);
		wr(ADDR_SYS_CTRL, d | 8'h80);
		rchk(ADDR_INFO_FLAGS, 8'h00);
		tick(4'h8);
		waitc(3);
		`CHK(o_rdy_oe, 1'b0)
		tick(4'hC);
		wait_rdy(1'b1);
		close_win();
		wr(ADDR_CFG, 8'h00);
		wr(ADDR_VER_LO, 8'h34);
		wr(ADDR_VER_HI, 8'h12);
		rchk(ADDR_VER_LO, 8'h34);
		rchk(ADDR_VER_HI, 8'h12);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_GEN_SET, 8'(i));
			`CHK(o_osc_sel, (i < 3) ? 2'(i) : 2'h2)
		end
		@(posedge i_clk) i_switch <= 1'b1;
		wr(ADDR_GEN_SET, 8'h10);
		waitc(4);
		`CHK(o_switch_pressed, 1'b0)
		wr(ADDR_GEN_SET, 8'h30);
		waitc(4);
		`CHK(o_switch_pressed, 1'b1)
		rchk(ADDR_INFO_FLAGS, 8'h01);
		wr(ADDR_GEN_SET, 8'h20);
		waitc(4);
		`CHK(o_switch_pressed, 1'b0)
		tick(4'h8);
		wait_rdy(1'b1);
		wr(ADDR_SYS_CTRL, 8'h08);
		close_win();
		`CHK(o_low_power, 1'b1)
		`CHK(o_processing_en, 1'b0)
		rchk(ADDR_INFO_FLAGS, 8'h02);
		tick(4'h2);
		wait_rdy(1'b1);
		wr(ADDR_SYS_CTRL, 8'h00);
		@(posedge i_clk) serve <= 1'b1;
		for (int k = 0; k < 50 && o_reseed !== 1'b1; k++) waitc(1);
		`CHK(o_reseed, 1'b1)
		`CHK(o_processing_en, 1'b1)
		@(posedge i_clk) serve <= 1'b0;
		wr(ADDR_TIMEOUT, 8'h02);
		tick(4'h8);
		wait_rdy(1'b1);
		waitc(10);
		`CHK(o_rdy_oe, 1'b1)
		wait_rdy(1'b0);
		`CHK(o_processing_en, 1'b1)
		tick(4'h8);
		wait_rdy(1'b1);
		wr(ADDR_SYS_CTRL, 8'h02);
		waitc(3);
		`CHK(o_core_reset, 1'b0)
		close_win();
		`CHK(o_core_reset, 1'b1)
		waitc(45);
		rchk(ADDR_INFO_FLAGS, 8'h80);
		rchk(ADDR_TIMEOUT, 8'h14);
		wr(ADDR_SYS_CTRL, 8'h80);
		// kick after 200 ticks keeps the count short of expiry
		lf(200);
		tick(4'h1);
		lf(200);
		`CHK(o_core_reset, 1'b0)
		lf(60);
		`CHK(o_core_reset, 1'b1)
		waitc(45);
		rchk(ADDR_INFO_FLAGS, 8'h80);
		wr(ADDR_SYS_CTRL, 8'h80);
		`CHK(o_rdy_oe, 1'b0)
		@(posedge i_clk) i_hardware_reset_pin_n <= 1'b0;
		waitc(5);
		`CHK(o_core_reset, 1'b1)
		@(posedge i_clk) i_hardware_reset_pin_n <= 1'b1;
		waitc(50);
		rchk(ADDR_INFO_FLAGS, 8'h80);
		summarize();
	end
endmodule : system_reset_suspend_control_test

bind system_reset_suspend_control sysctl_checker chk (.i_clk(i_clk), .i_rstn(i_rstn),
	.i_rd(i_rd), .i_cycle_done(i_cycle_done), .i_comm_end(i_comm_end),
	.i_force_comms(i_force_comms), .o_rdata(o_rdata), .o_processing_en(o_processing_en),
	.o_low_power(o_low_power), .o_reseed(o_reseed), .o_core_reset(o_core_reset),
	.o_rdy_o(o_rdy_o), .o_rdy_oe(o_rdy_oe));
